// File: src/glitchless_clock_select_fanout.sv
// Glitch-free two-input clock selector with eight true/complement output pairs
`timescale 1ns/100ps
module glitchless_clock_select_fanout #(
   parameter int DEAD_LIMIT = clock_select_pkg::DEAD_CYCLES
) (
   input  wire logic                           ref_clk,
   input  wire logic                           reset_n,
   input  wire logic                           clock_input_a,
   input  wire logic                           clock_input_b,
   input  wire logic                           input_select,
   input  wire logic                           startup_delay_pin,
   output clock_select_pkg::fanout_pair_s      fanout_outputs,
   output logic                                failsafe_hold,
   output logic                                switch_busy
);
   import clock_select_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] clk_sync;
   logic       sel_sync;
   logic       bypass_sync;

   // The input clocks are sampled as plain data, so each must stay well below
   // half of ref_clk or edges are lost
   level_sync #(.RESET_VAL(1'b0)) sync_clk_a (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in (clock_input_a),
      .sync_out (clk_sync[0])
   );
   level_sync #(.RESET_VAL(1'b0)) sync_clk_b (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in (clock_input_b),
      .sync_out (clk_sync[1])
   );
   // Reset value high models the pull-up on an open select pin
   level_sync #(.RESET_VAL(SEL_RESET_VAL)) sync_sel (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in (input_select),
      .sync_out (sel_sync)
   );
   // Reset value low keeps suppression on until the startup pin is seen high,
   // so a tied-high pin takes effect two cycles after reset
   level_sync #(.RESET_VAL(1'b0)) sync_bypass (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in (startup_delay_pin),
      .sync_out (bypass_sync)
   );

   // ----------------------------------------------------------------
   // Edge and activity tracking per input clock
   // ----------------------------------------------------------------
   logic [1:0]            clk_prev;
   logic [1:0]            next_clk_prev;
   logic [IDLE_CNT_W-1:0] idle_cnt [2];
   logic [IDLE_CNT_W-1:0] next_idle_cnt [2];
   logic [1:0]            fall;
   logic [1:0]            dead;

   // The idle counters saturate, so a clock that stays stopped keeps its dead
   // flag without wrapping back to a false restart
   always_comb begin
      next_clk_prev = clk_sync;
      for (int i = 0; i < 2; i++) begin
         fall[i] = clk_prev[i] & ~clk_sync[i];
         dead[i] = (idle_cnt[i] == IDLE_CNT_W'(DEAD_LIMIT));
         if (clk_prev[i] != clk_sync[i]) begin
            next_idle_cnt[i] = '0;
         end else if (dead[i]) begin
            next_idle_cnt[i] = idle_cnt[i];
         end else begin
            next_idle_cnt[i] = idle_cnt[i] + IDLE_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_prev    <= 2'h0;
         idle_cnt[0] <= '0;
         idle_cnt[1] <= '0;
      end else begin
         clk_prev    <= next_clk_prev;
         idle_cnt[0] <= next_idle_cnt[0];
         idle_cnt[1] <= next_idle_cnt[1];
      end
   end

   // ----------------------------------------------------------------
   // Switchover state machine
   // ----------------------------------------------------------------
   switch_state_e          state;
   switch_state_e          next_state;
   logic                   active;
   logic                   next_active;
   logic                   out_level;
   logic                   next_out_level;
   logic [POR_CNT_W-1:0]   por_cnt;
   logic [POR_CNT_W-1:0]   next_por_cnt;
   logic                   next_failsafe_hold;
   logic                   next_switch_busy;
   fanout_pair_s           next_fanout;

   // Limitation: if the new clock dies while the output is parked low, the
   // switchover waits there until bypass or reset; the low level is stable
   always_comb begin
      next_state         = state;
      next_active        = active;
      next_out_level     = out_level;
      next_por_cnt       = por_cnt;
      unique case (state)
         ST_INIT: begin
            // Output parked low until the initialisation count expires
            next_out_level = 1'b0;
            if (por_cnt == POR_CNT_W'(POR_CYCLES - 1)) begin
               next_state  = ST_FOLLOW;
               next_active = sel_sync;
            end else begin
               next_por_cnt = por_cnt + POR_CNT_W'(1);
            end
         end
         ST_FOLLOW: begin
            if (bypass_sync && sel_sync != active) begin
               // Plain multiplexer behaviour, runts allowed
               next_active    = sel_sync;
               next_out_level = clk_sync[sel_sync];
            end else begin
               if (!dead[active]) begin
                  next_out_level = clk_sync[active];
               end // else hold last valid level
               if (sel_sync != active) begin
                  next_state = ST_DRAIN;
               end
            end
         end
         ST_DRAIN: begin
            // Keep following the old clock until it falls
            if (bypass_sync) begin
               next_state     = ST_FOLLOW;
               next_active    = sel_sync;
               next_out_level = clk_sync[sel_sync];
            end else if (fall[active] || (dead[active] && fall[~active])) begin
               // A stuck old clock is released on the new clock's fall, so
               // a held high phase is never shorter than half a new period
               next_state     = ST_LOW;
               next_active    = ~active;
               next_out_level = 1'b0;
            end else if (!dead[active]) begin
               next_out_level = clk_sync[active];
            end
         end
         ST_LOW: begin
            // Low until the new clock's next fall before passing it
            next_out_level = 1'b0;
            if (fall[active] || bypass_sync) begin
               next_state = ST_FOLLOW;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= ST_INIT;
         active    <= SEL_CLOCK_A;
         out_level <= 1'b0;
         por_cnt   <= '0;
      end else begin
         state     <= next_state;
         active    <= next_active;
         out_level <= next_out_level;
         por_cnt   <= next_por_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   // The pairs load the next level rather than out_level, so the pins add
   // no cycle of delay behind the state machine
   always_comb begin
      // Hold only reports; the frozen level lives in out_level itself
      next_failsafe_hold   = dead[active];
      next_switch_busy     = (next_state == ST_DRAIN) || (next_state == ST_LOW);
      next_fanout.true_leg = {FANOUT_WIDTH{next_out_level}};
      next_fanout.comp_leg = {FANOUT_WIDTH{~next_out_level}};
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Every true leg low and every complement high while in reset
         failsafe_hold  <= 1'b0;
         switch_busy    <= 1'b0;
         fanout_outputs <= '{true_leg: '0, comp_leg: '1};
      end else begin
         failsafe_hold  <= next_failsafe_hold;
         switch_busy    <= next_switch_busy;
         fanout_outputs <= next_fanout;
      end
   end
endmodule

// File: shared/clock_select_pkg.sv
// Constants, states and output carrier for the glitch-free clock selector
package clock_select_pkg;
   localparam int          FANOUT_WIDTH  = 8;
   localparam int          CLK_PERIOD_NS = 4;
   // Power-on settling time that the switchover logic waits before selecting
   localparam int          POR_TIME_NS   = 1000;
   localparam int          POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          POR_CNT_W     = 9;
   // Longer than half a period of the slowest valid input clock (1 kHz)
   localparam int          DEAD_TIME_NS  = 1000000;
   localparam int          DEAD_CYCLES   = DEAD_TIME_NS / CLK_PERIOD_NS;
   localparam int          IDLE_CNT_W    = 20;
   localparam logic        SEL_RESET_VAL = 1'b1;
   localparam logic        SEL_CLOCK_A   = 1'b0;

   typedef enum logic [1:0] {
      ST_INIT   = 2'b00,
      ST_FOLLOW = 2'b01,
      ST_DRAIN  = 2'b10,
      ST_LOW    = 2'b11
   } switch_state_e;

   typedef struct packed {
      logic [FANOUT_WIDTH-1:0] true_leg;
      logic [FANOUT_WIDTH-1:0] comp_leg;
   } fanout_pair_s;
endpackage

// File: src/level_sync.sv
// Two-flop synchroniser for one level from outside the ref_clk domain
`timescale 1ns/100ps
module level_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic first_stage;
   logic next_first_stage;
   logic next_sync_out;

   always_comb begin
      next_first_stage = async_in;
      next_sync_out    = first_stage;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         first_stage <= RESET_VAL;
         sync_out    <= RESET_VAL;
      end else begin
         first_stage <= next_first_stage;
         sync_out    <= next_sync_out;
      end
   end
endmodule

// File: verification/clock_source_pair.sv
// Two clock sources that can stop at their present level
`timescale 1ns/100ps
module clock_source_pair #(
   parameter real HALF_A = 20.0,
   parameter real HALF_B = 28.0
) (
   input  wire logic run_a,
   input  wire logic run_b,
   output logic      clock_input_a,
   output logic      clock_input_b
);
   // Ratio 28/20 keeps within 1.5:1; 1 ns offset keeps edges off ref_clk edges
   initial begin
      clock_input_a = 1'b0;
      #1;
      forever #(HALF_A) if (run_a) clock_input_a = ~clock_input_a;
   end
   initial begin
      clock_input_b = 1'b0;
      #1;
      forever #(HALF_B) if (run_b) clock_input_b = ~clock_input_b;
   end
endmodule

// File: verification/glitchless_clock_select_fanout_asserts.sv
// Port checker for the clock selector
`timescale 1ns/100ps
module glitchless_clock_select_fanout_asserts #(
   parameter int DEAD_LIMIT = 64
) (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire logic                      clock_input_a,
   input  wire logic                      clock_input_b,
   input  wire logic                      input_select,
   input  wire logic                      startup_delay_pin,
   input  clock_select_pkg::fanout_pair_s fanout_outputs,
   input  wire logic                      failsafe_hold,
   input  wire logic                      switch_busy
);
   import clock_select_pkg::*;
   logic [8:0] por_cnt;
   logic [7:0] idle_cnt;
   logic [1:0] last;
   logic       sel_clk;
   logic       tl;
   assign sel_clk = input_select ? clock_input_b : clock_input_a;
   assign tl      = fanout_outputs.true_leg[0];
   // Idle count restarts on any move of select or of the chosen clock
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         por_cnt  <= 9'h000;
         idle_cnt <= 8'h00;
         last     <= 2'h0;
      end else begin
         last <= {input_select, sel_clk};
         if (por_cnt != 9'h1FF) por_cnt <= por_cnt + 9'h001;
         if (last != {input_select, sel_clk}) idle_cnt <= 8'h00;
         else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_rise; por_cnt > 9'h108 && $rose(tl); endsequence
   sequence s_fall; por_cnt > 9'h108 && $fell(tl); endsequence
   sequence s_drop_busy; switch_busy && $past(switch_busy) && $fell(tl); endsequence
   a_comp_inverse: assert property (fanout_outputs.comp_leg == ~fanout_outputs.true_leg)
      else $error("complement leg is not the inverse");
   a_legs_equal: assert property (fanout_outputs.true_leg == 8'h00 || fanout_outputs.true_leg == 8'hFF)
      else $error("output pairs disagree");
   a_init_low: assert property (por_cnt < 9'h0F0 |-> fanout_outputs.true_leg == 8'h00)
      else $error("output active during init");
   a_bypass_follow: assert property (por_cnt > 9'h104 && (startup_delay_pin && $stable(input_select))[*8] |-> tl == $past(sel_clk, 3))
      else $error("plain mux output wrong");
   a_no_runt_high: assert property (disable iff (!reset_n || startup_delay_pin) s_rise |-> tl[*4])
      else $error("short high pulse");
   a_no_runt_low: assert property (disable iff (!reset_n || startup_delay_pin) s_fall |-> (!tl)[*4])
      else $error("short low pulse");
   a_low_until_done: assert property (disable iff (!reset_n || startup_delay_pin) s_drop_busy |-> (!tl) until (!switch_busy))
      else $error("output not low in switchover");
   a_busy_bounded: assert property ($rose(switch_busy) |-> ##[1:64] !switch_busy)
      else $error("switchover too long");
   a_hold_stable: assert property ((failsafe_hold && !switch_busy)[*2] |-> $stable(fanout_outputs))
      else $error("output moved while held");
   a_hold_raise: assert property (por_cnt > 9'h104 && idle_cnt == DEAD_LIMIT + 8 |-> failsafe_hold)
      else $error("dead clock not reported");
endmodule

// File: verification/glitchless_clock_select_fanout_tb.sv
// Self-checking bench for the clock selector
`timescale 1ns/100ps
module glitchless_clock_select_fanout_tb;
   import clock_select_pkg::*;
   localparam int DEAD = 64;
   logic         ref_clk;
   logic         reset_n;
   logic         clock_input_a;
   logic         clock_input_b;
   tri1          input_select;
   logic         sel_drv;
   logic         sel_en;
   logic         startup_delay_pin;
   logic         run_a;
   logic         run_b;
   fanout_pair_s fanout_outputs;
   logic         failsafe_hold;
   logic         switch_busy;
   logic [2:0]   hist_a;
   logic [2:0]   hist_b;
   int           err_total = 0;
   int           num_checks = 0;
   int           cycles = 0;
   // Pull-up stands in for the pad, so a released select reads high
   assign input_select = sel_en ? sel_drv : 1'bz;
   clock_source_pair clock_source_pair_i (.run_a(run_a), .run_b(run_b),
      .clock_input_a(clock_input_a), .clock_input_b(clock_input_b));
   glitchless_clock_select_fanout #(.DEAD_LIMIT(DEAD)) glitchless_clock_select_fanout_i (.ref_clk(ref_clk),
      .reset_n(reset_n), .clock_input_a(clock_input_a), .clock_input_b(clock_input_b),
      .input_select(input_select), .startup_delay_pin(startup_delay_pin), .fanout_outputs(fanout_outputs),
      .failsafe_hold(failsafe_hold), .switch_busy(switch_busy));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Three-deep history matches two sync flops plus the output flop
   always @(posedge ref_clk) begin
      hist_a <= {hist_a[1:0], clock_input_a};
      hist_b <= {hist_b[1:0], clock_input_b};
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic follow(input logic use_b, input int n);
      logic e;
      repeat (n) begin
         @(negedge ref_clk);
         e = use_b ? hist_b[2] : hist_a[2];
         check(fanout_outputs, {{8{e}}, {8{~e}}});
      end
   endtask
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 100 && switch_busy !== lvl; i++) @(negedge ref_clk);
      check({15'h0000, switch_busy}, {15'h0000, lvl});
   endtask
   task automatic t_switch(input logic to_b);
      @(negedge ref_clk);
      sel_en = 1'b1;
      sel_drv = to_b;
      wait_busy(1'b1);
      wait_busy(1'b0);
      follow(to_b, 80);
   endtask
   task automatic t_bypass;
      startup_delay_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      sel_drv = 1'b0;
      repeat (4) @(negedge ref_clk);
      check({15'h0000, switch_busy}, 16'h0000);
      follow(1'b0, 60);
      startup_delay_pin = 1'b0;
   endtask
   // Stops clock_input_b at a chosen level so both stuck cases are reached
   task automatic t_dead_clock(input logic lvl);
      while (clock_input_b !== lvl) @(negedge ref_clk);
      run_b = 1'b0;
      repeat (DEAD + 12) @(negedge ref_clk);
      check({15'h0000, failsafe_hold}, 16'h0001);
      check(fanout_outputs, {{8{lvl}}, {8{~lvl}}});
      t_switch(1'b0);
      check({15'h0000, failsafe_hold}, 16'h0000);
      run_b = 1'b1;
   endtask
   task automatic t_reset;
      reset_n = 1'b0;
      @(negedge ref_clk);
      check(fanout_outputs, 16'h00FF);
      check({14'h0000, failsafe_hold, switch_busy}, 16'h0000);
      reset_n = 1'b1;
      repeat (100) @(negedge ref_clk);
      check(fanout_outputs, 16'h00FF);
      repeat (170) @(negedge ref_clk);
      follow(1'b0, 60);
   endtask
   task automatic t_open_select;
      repeat (260) @(negedge ref_clk);
      follow(1'b1, 80);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      sel_en = 1'b0;
      sel_drv = 1'b1;
      startup_delay_pin = 1'b0;
      run_a = 1'b1;
      run_b = 1'b1;
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      t_open_select();
      t_switch(1'b0);
      t_switch(1'b1);
      t_bypass();
      t_switch(1'b1);
      t_dead_clock(1'b1);
      t_switch(1'b1);
      t_dead_clock(1'b0);
      t_reset();
      end_of_test();
   end
endmodule
bind glitchless_clock_select_fanout glitchless_clock_select_fanout_asserts #(.DEAD_LIMIT(DEAD_LIMIT))
   glitchless_clock_select_fanout_asserts_i (.ref_clk(ref_clk), .reset_n(reset_n),
   .clock_input_a(clock_input_a), .clock_input_b(clock_input_b), .input_select(input_select),
   .startup_delay_pin(startup_delay_pin), .fanout_outputs(fanout_outputs),
   .failsafe_hold(failsafe_hold), .switch_busy(switch_busy));
